/* hsp_pkg.sv */
// hsp_pkg: shared constants for the two-slot hot-swap power sequencer
// assumes a 200 MHz mclk; every timing figure is turned into cycles here
package hsp_pkg;

    // ------------------------------------------------------------
    // clock and timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ          = 200;
    localparam int POR_TIME_US      = 250;
    localparam int POR_CYCLES       = POR_TIME_US * CLK_MHZ;
    localparam int FLT_TIME_US      = 10;
    localparam int FLT_CYCLES       = FLT_TIME_US * CLK_MHZ;
    localparam int PULSE_TIME_NS    = 100;
    localparam int PULSE_CYCLES     = (PULSE_TIME_NS * CLK_MHZ + 999) / 1000;
    localparam int AUX_FLT_TIME_NS  = 1000;
    localparam int AUX_FLT_CYCLES   = AUX_FLT_TIME_NS * CLK_MHZ / 1000;
    localparam int CNT_W            = 24;

    // ------------------------------------------------------------
    // register map (word index = byte address / 4 is not used: plain port)
    // ------------------------------------------------------------
    localparam logic [3:0] REG_CTRL   = 4'h0;
    localparam logic [3:0] REG_STAT   = 4'h1;
    localparam logic [3:0] REG_MASK   = 4'h2;
    localparam logic [3:0] REG_PINS   = 4'h3;
    localparam logic [3:0] REG_IDENT  = 4'h4;

    // ctrl fields
    localparam int CTRL_MODE_BIT    = 0;
    localparam int CTRL_MAIN_A_BIT  = 1;
    localparam int CTRL_AUX_A_BIT   = 2;
    localparam int CTRL_MAIN_B_BIT  = 3;
    localparam int CTRL_AUX_B_BIT   = 4;
    localparam int CTRL_IMASK_BIT   = 5;

    // status fields: per slot {aux_oc, main_oc}, slot a low
    localparam int STAT_W           = 4;

    // reset values
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [3:0] STAT_RST = 4'h0;
    localparam logic [3:0] MASK_RST = 4'h0;

    // arbitrary identification value
    localparam logic [7:0] IDENT_VAL = 8'h5a;

    // sequencer states
    typedef enum logic [1:0] {
        HSP_ST_WAIT,
        HSP_ST_QUAL,
        HSP_ST_CLEAR,
        HSP_ST_RUN
    } hsp_state_t;

endpackage

/* hsp_sync.sv */
// hsp_sync: two-flip-flop synchroniser for a vector of pin levels
// assumes inputs are asynchronous to mclk
`timescale 1ns/1ps
module hsp_sync #(
    parameter int W = 1
) (
    input  wire logic         mclk,
    input  wire logic         sys_rst,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);
    import hsp_pkg::*;

    logic [W-1:0] meta_ff;

    // ------------------------------------------------------------
    // two stages; only the second stage is visible
    // ------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            meta_ff  <= '0;
            sync_out <= '0;
        end else begin
            meta_ff  <= async_in;
            sync_out <= meta_ff;
        end
    end
endmodule

/* hsp_timer.sv */
// hsp_timer: qualification counter, restarts whenever its condition drops
// assumes cond is synchronous to mclk
`timescale 1ns/1ps
module hsp_timer #(
    parameter int LIMIT = 16
) (
    input  wire logic mclk,
    input  wire logic sys_rst,
    input  wire logic cond,
    output logic      done
);
    import hsp_pkg::*;

    logic [CNT_W-1:0] cnt_ff;
    logic [CNT_W-1:0] nxt_cnt;
    wire              at_limit = (cnt_ff >= CNT_W'(LIMIT - 1));

    // count up while cond holds, clear on drop
    assign nxt_cnt = !cond ? '0 : (at_limit ? cnt_ff : cnt_ff + 1'b1);

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            cnt_ff <= '0;
            done   <= 1'b0;
        end else begin
            cnt_ff <= nxt_cnt;
            done   <= cond && at_limit;
        end
    end
endmodule

/* hsp_sequencer.sv */
// hsp_sequencer: digital core of a two-slot hot-swap power controller
// assumes pins arrive asynchronously; the register port is on mclk
`timescale 1ns/1ps
module hsp_sequencer #(
    parameter int POR_CNT = hsp_pkg::POR_CYCLES,
    parameter int FLT_CNT = hsp_pkg::FLT_CYCLES
) (
    input  wire logic       mclk,
    input  wire logic       sys_rst,
    input  wire logic       standby_supply,
    input  wire logic [1:0] slot_main_enable,
    input  wire logic [1:0] slot_aux_enable,
    input  wire logic [1:0] general_input_pin,
    input  wire logic [1:0] main_oc_detect,
    input  wire logic [1:0] aux_oc_detect,
    input  wire logic [3:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    output logic            reg_ready,
    output logic      [1:0] high_rail_gate_ctrl,
    output logic      [1:0] low_rail_gate_ctrl,
    output logic      [1:0] gate_cc_en,
    output logic      [1:0] aux_output,
    output logic      [1:0] slot_fault_n,
    output logic            irq_n
);
    import hsp_pkg::*;

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [9:0] pin_s;

    hsp_sync #(.W(10)) u_sync (
        .mclk     (mclk),
        .sys_rst  (sys_rst),
        .async_in ({aux_oc_detect, main_oc_detect, general_input_pin,
                    slot_aux_enable, slot_main_enable}),
        .sync_out (pin_s)
    );

    wire [1:0] main_en_s = pin_s[1:0];
    wire [1:0] aux_en_s  = pin_s[3:2];
    wire [1:0] gpi_s     = pin_s[5:4];
    wire [1:0] moc_s     = pin_s[7:6];
    wire [1:0] aoc_s     = pin_s[9:8];

    logic stby_m_ff;
    logic stby_s_ff;

    // standby level crossing
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            stby_m_ff <= 1'b0;
            stby_s_ff <= 1'b0;
        end else begin
            stby_m_ff <= standby_supply;
            stby_s_ff <= stby_m_ff;
        end
    end

    // ------------------------------------------------------------
    // power-on reset sequencing
    // ------------------------------------------------------------
    hsp_state_t state_ff;
    hsp_state_t nxt_state;
    logic       por_done;

    hsp_timer #(.LIMIT(POR_CNT)) u_por (
        .mclk    (mclk),
        .sys_rst (sys_rst),
        .cond    (stby_s_ff),
        .done    (por_done)
    );

    // any dropout forces back to wait
    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            HSP_ST_WAIT:  if (stby_s_ff) nxt_state = HSP_ST_QUAL;
            HSP_ST_QUAL:  if (por_done) nxt_state = HSP_ST_CLEAR;
            HSP_ST_CLEAR: nxt_state = HSP_ST_RUN;
            HSP_ST_RUN:   nxt_state = HSP_ST_RUN;
        endcase
        if (!stby_s_ff) nxt_state = HSP_ST_WAIT;
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) state_ff <= HSP_ST_WAIT;
        else         state_ff <= nxt_state;
    end

    wire running  = (state_ff == HSP_ST_RUN);
    wire clearing = (state_ff != HSP_ST_RUN);

    // ------------------------------------------------------------
    // register decode
    // ------------------------------------------------------------
    logic [7:0]        ctrl_ff;
    logic [STAT_W-1:0] stat_ff;
    logic [STAT_W-1:0] mask_ff;

    wire acc_ok   = running;
    wire wr_ok    = reg_wr && acc_ok;
    wire rd_ok    = reg_rd && acc_ok;
    wire wr_ctrl  = wr_ok && (reg_addr == REG_CTRL);
    wire wr_stat  = wr_ok && (reg_addr == REG_STAT);
    wire wr_mask  = wr_ok && (reg_addr == REG_MASK);
    wire rd_stat  = rd_ok && (reg_addr == REG_STAT);
    wire pin_mode = ctrl_ff[CTRL_MODE_BIT];

    // in pin mode the power bits keep their value, other bits still written
    wire [7:0] pwr_bits = 8'h1e;
    wire [7:0] wr_keep  = pin_mode ? pwr_bits : 8'h00;
    wire [7:0] nxt_ctrl = clearing ? CTRL_RST :
                          wr_ctrl ? ((reg_wdata & ~wr_keep) | (ctrl_ff & wr_keep)) : ctrl_ff;

    // ------------------------------------------------------------
    // slot power and faults, one generate per slot
    // ------------------------------------------------------------
    logic [1:0] main_req;
    logic [1:0] aux_req;
    logic [1:0] main_trip_ff;
    logic [1:0] aux_trip_ff;
    logic [1:0] main_flt_done;
    logic [1:0] aux_flt_done;
    logic [STAT_W-1:0] fault_evt;

    genvar s;
    generate
        for (s = 0; s < 2; s++) begin : g_slot
            // path selection by mode
            assign main_req[s] = pin_mode ? main_en_s[s] : ctrl_ff[CTRL_MAIN_A_BIT + 2*s];
            assign aux_req[s]  = pin_mode ? aux_en_s[s]  : ctrl_ff[CTRL_AUX_A_BIT + 2*s];

            hsp_timer #(.LIMIT(FLT_CNT)) u_mflt (
                .mclk    (mclk),
                .sys_rst (sys_rst),
                .cond    (moc_s[s] && main_req[s] && !main_trip_ff[s]),
                .done    (main_flt_done[s])
            );

            hsp_timer #(.LIMIT(1)) u_aflt (
                .mclk    (mclk),
                .sys_rst (sys_rst),
                .cond    (aoc_s[s] && aux_req[s] && !aux_trip_ff[s]),
                .done    (aux_flt_done[s])
            );

            assign fault_evt[2*s]   = main_flt_done[s];
            assign fault_evt[2*s+1] = aux_flt_done[s];

            // trips latch until the request is withdrawn
            always_ff @(posedge mclk) begin
                if (sys_rst || clearing) begin
                    main_trip_ff[s] <= 1'b0;
                    aux_trip_ff[s]  <= 1'b0;
                end else begin
                    main_trip_ff[s] <= main_req[s] && (main_trip_ff[s] || main_flt_done[s]);
                    aux_trip_ff[s]  <= aux_req[s] && (aux_trip_ff[s] || aux_flt_done[s]);
                end
            end

            wire main_on = running && main_req[s] && !main_trip_ff[s] && !main_flt_done[s];
            wire aux_on  = running && aux_req[s] && !aux_trip_ff[s] && !aux_flt_done[s];

            // gate drive: off pulls high rail high, low rail low
            always_ff @(posedge mclk) begin
                if (sys_rst) begin
                    high_rail_gate_ctrl[s] <= 1'b1;
                    low_rail_gate_ctrl[s]  <= 1'b0;
                    gate_cc_en[s]          <= 1'b0;
                    aux_output[s]          <= 1'b0;
                    slot_fault_n[s]        <= 1'b1;
                end else begin
                    high_rail_gate_ctrl[s] <= !main_on;
                    low_rail_gate_ctrl[s]  <= main_on;
                    gate_cc_en[s]          <= main_on;
                    aux_output[s]          <= aux_on;
                    slot_fault_n[s]        <= !(pin_mode && (main_trip_ff[s] || aux_trip_ff[s]
                                               || aux_flt_done[s]));
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // status, mask and interrupt
    // ------------------------------------------------------------
    // set wins over write-one-to-clear and read-clear
    wire [STAT_W-1:0] clr_bits = (wr_stat ? reg_wdata[STAT_W-1:0] : '0)
                               | (rd_stat ? {STAT_W{1'b1}} : '0);
    wire [STAT_W-1:0] nxt_stat = clearing ? STAT_RST
                               : ((stat_ff & ~clr_bits) | fault_evt);
    wire [STAT_W-1:0] nxt_mask = clearing ? MASK_RST : (wr_mask ? reg_wdata[STAT_W-1:0] : mask_ff);
    wire              irq_on   = |(nxt_stat & ~nxt_mask) && !ctrl_ff[CTRL_IMASK_BIT];

    // read mux
    wire [7:0] rd_mux = (reg_addr == REG_CTRL)  ? ctrl_ff :
                        (reg_addr == REG_STAT)  ? {4'h0, stat_ff} :
                        (reg_addr == REG_MASK)  ? {4'h0, mask_ff} :
                        (reg_addr == REG_PINS)  ? {6'h00, gpi_s} :
                        (reg_addr == REG_IDENT) ? IDENT_VAL : 8'h00;

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            ctrl_ff   <= CTRL_RST;
            stat_ff   <= STAT_RST;
            mask_ff   <= MASK_RST;
            reg_rdata <= 8'h00;
            reg_ready <= 1'b0;
            irq_n     <= 1'b1;
        end else begin
            ctrl_ff   <= nxt_ctrl;
            stat_ff   <= nxt_stat;
            mask_ff   <= nxt_mask;
            reg_rdata <= rd_ok ? rd_mux : 8'h00;
            reg_ready <= running;
            irq_n     <= !(irq_on && !clearing);
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence stby_drop_s;
        !stby_s_ff;
    endsequence

    sequence qual_run_s;
        stby_s_ff [*8];
    endsequence

    por_start_a: assert property (@(posedge mclk) disable iff (sys_rst)
        $rose(state_ff == HSP_ST_CLEAR) |-> $past(por_done))
        else $error("por ended before qualification");

    por_restart_a: assert property (@(posedge mclk) disable iff (sys_rst)
        stby_drop_s |=> state_ff == HSP_ST_WAIT)
        else $error("standby drop did not restart");

    reg_clear_a: assert property (@(posedge mclk) disable iff (sys_rst)
        state_ff == HSP_ST_CLEAR |=> ctrl_ff == CTRL_RST && stat_ff == STAT_RST)
        else $error("registers not cleared after por");

    bus_refuse_a: assert property (@(posedge mclk) disable iff (sys_rst)
        !running |=> !reg_ready && reg_rdata == 8'h00)
        else $error("access during por");

    outs_off_a: assert property (@(posedge mclk) disable iff (sys_rst)
        !running |=> aux_output == 2'b00 && gate_cc_en == 2'b00)
        else $error("output on during por");

    gate_off_a: assert property (@(posedge mclk) disable iff (sys_rst)
        !gate_cc_en[0] |-> high_rail_gate_ctrl[0] && !low_rail_gate_ctrl[0])
        else $error("gate not in off state");

    gate_drive_a: assert property (@(posedge mclk) disable iff (sys_rst)
        running && main_req[0] && !main_trip_ff[0] && !main_flt_done[0]
        |=> gate_cc_en[0] && !high_rail_gate_ctrl[0])
        else $error("gate not driven on enable");

    aux_fault_a: assert property (@(posedge mclk) disable iff (sys_rst)
        pin_mode && aux_flt_done[1] && running |=> !slot_fault_n[1])
        else $error("aux fault not reported");

    irq_set_a: assert property (@(posedge mclk) disable iff (sys_rst)
        running && |(fault_evt & ~nxt_mask) && !ctrl_ff[CTRL_IMASK_BIT] |=> !irq_n)
        else $error("interrupt missed a fault");

    main_trip_a: assert property (@(posedge mclk) disable iff (sys_rst)
        running && main_flt_done[0] && main_req[0] |=> main_trip_ff[0] && !gate_cc_en[0])
        else $error("main trip did not shut off");

    qual_hold_a: assert property (@(posedge mclk) disable iff (sys_rst)
        state_ff == HSP_ST_WAIT ##1 qual_run_s |-> state_ff != HSP_ST_RUN || POR_CNT < 9)
        else $error("por finished too early");

    pwr_keep_a: assert property (@(posedge mclk) disable iff (sys_rst)
        running && pin_mode && wr_ctrl |=> $stable(ctrl_ff[CTRL_AUX_B_BIT:CTRL_MAIN_A_BIT]))
        else $error("power bits written in pin mode");
endmodule

/* hsp_host_model.sv */
// hsp_host_model: hot-plug controller side that drives the slot enable pins
// assumes the bench asks for pin levels on mclk; it owns only the enable pins
`timescale 1ns/1ps
module hsp_host_model
    import hsp_pkg::*;
(
    input  wire logic       mclk,
    input  wire logic       sys_rst,
    input  wire logic       pin_mode,
    input  wire logic [1:0] want_main,
    input  wire logic [1:0] want_aux,
    output logic      [1:0] slot_main_enable,
    output logic      [1:0] slot_aux_enable
);
    int hold_cnt;

    // ------------------------------------------------------------
    // pin driver
    // ------------------------------------------------------------
    // pins tied inactive unless the pins own slot power
    // a level may change only after the last one stood long enough
    always @(posedge mclk) begin
        if (sys_rst || !pin_mode) begin
            slot_main_enable <= 2'h0;
            slot_aux_enable  <= 2'h0;
            hold_cnt         <= 0;
        end else if (hold_cnt < PULSE_CYCLES) begin
            hold_cnt <= hold_cnt + 1;
        end else if (want_main != slot_main_enable || want_aux != slot_aux_enable) begin
            slot_main_enable <= want_main;
            slot_aux_enable  <= want_aux;
            hold_cnt         <= 0;
        end
    end
endmodule

/* tb_hotswap_slot_power_sequencer.sv */
// tb_hotswap_slot_power_sequencer: self-checking bench for hsp_sequencer
// assumes shortened counts: 20 cycles of qualification, 8 of fault filter
`timescale 1ns/1ps
module tb_hotswap_slot_power_sequencer;
    import hsp_pkg::*;
    localparam int POR_SIM = 20;
    localparam int FLT_SIM = 8;

    logic       mclk = 1'b0;
    logic       sys_rst = 1'b1;
    logic       standby_supply = 1'b0;
    logic [1:0] slot_main_enable;
    logic [1:0] slot_aux_enable;
    logic [1:0] general_input_pin = 2'h0;
    logic [1:0] main_oc_detect = 2'h0;
    logic [1:0] aux_oc_detect = 2'h0;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic       reg_wr = 1'b0;
    logic       reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    logic       reg_ready;
    logic [1:0] high_rail_gate_ctrl;
    logic [1:0] low_rail_gate_ctrl;
    logic [1:0] gate_cc_en;
    logic [1:0] aux_output;
    logic [1:0] slot_fault_n;
    logic       irq_n;
    logic       pin_mode = 1'b0;
    logic [1:0] want_main = 2'h0;
    logic [1:0] want_aux = 2'h0;
    int         num_errors = 0;
    int         total_checks = 0;
    int         wait_n;

    // ------------------------------------------------------------
    // clock, design and far side
    // ------------------------------------------------------------
    always #2.5 mclk = ~mclk;

    hsp_sequencer #(.POR_CNT(POR_SIM), .FLT_CNT(FLT_SIM)) i_dut (
        .mclk(mclk), .sys_rst(sys_rst), .standby_supply(standby_supply),
        .slot_main_enable(slot_main_enable), .slot_aux_enable(slot_aux_enable),
        .general_input_pin(general_input_pin), .main_oc_detect(main_oc_detect),
        .aux_oc_detect(aux_oc_detect), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_ready(reg_ready),
        .high_rail_gate_ctrl(high_rail_gate_ctrl), .low_rail_gate_ctrl(low_rail_gate_ctrl),
        .gate_cc_en(gate_cc_en), .aux_output(aux_output), .slot_fault_n(slot_fault_n),
        .irq_n(irq_n));

    hsp_host_model i_host (
        .mclk(mclk), .sys_rst(sys_rst), .pin_mode(pin_mode), .want_main(want_main),
        .want_aux(want_aux), .slot_main_enable(slot_main_enable),
        .slot_aux_enable(slot_aux_enable));

    // ------------------------------------------------------------
    // access and compare tasks
    // ------------------------------------------------------------
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr    <= 1'b0;
    endtask

    task automatic rd_chk(input string name, input logic [3:0] a, input logic [7:0] exp);
        @(posedge mclk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd   <= 1'b0;
        #1;
        chk(name, exp, reg_rdata);
    endtask

    // counts cycles from now until the block reports ready
    task automatic wait_ready(output int n);
        n = 0;
        while (reg_ready !== 1'b1 && n < 80) begin
            cyc(1);
            n++;
        end
    endtask

    // powers slot a from registers, then overloads main past the filter
    task automatic trip_a();
        wr(REG_CTRL, 8'h00);
        wr(REG_CTRL, 8'h06);
        cyc(3);
        @(posedge mclk) main_oc_detect <= 2'h1;
        cyc(FLT_SIM + 6);
        @(posedge mclk) main_oc_detect <= 2'h0;
        cyc(3);
    endtask

    task automatic wrap_up();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // ------------------------------------------------------------
    // watchdog
    // ------------------------------------------------------------
    initial begin
        #(5ns * 20000);
        num_errors++;
        wrap_up();
    end

    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        repeat (8) @(posedge mclk);
        sys_rst <= 1'b0;
        cyc(2);
        rd_chk("early read", REG_IDENT, 8'h00);
        chk("gate cc off", 8'h00, {6'h0, gate_cc_en});
        // a dropout mid-qualification must restart the full count
        @(posedge mclk) standby_supply <= 1'b1;
        cyc(12);
        @(posedge mclk) standby_supply <= 1'b0;
        cyc(4);
        @(posedge mclk) standby_supply <= 1'b1;
        cyc(1);
        wait_ready(wait_n);
        chk("ready late", 8'h01, {7'h0, wait_n >= POR_SIM});
        chk("ready seen", 8'h01, {7'h0, reg_ready});
        rd_chk("ctrl clear", REG_CTRL, CTRL_RST);
        rd_chk("stat clear", REG_STAT, {4'h0, STAT_RST});
        rd_chk("mask clear", REG_MASK, {4'h0, MASK_RST});
        rd_chk("ident", REG_IDENT, IDENT_VAL);
        rd_chk("unmapped", 4'hf, 8'h00);
        chk("hi gate off", 8'h03, {6'h0, high_rail_gate_ctrl});
        chk("lo gate off", 8'h00, {6'h0, low_rail_gate_ctrl});
        // register mode power-up of slot a
        wr(REG_CTRL, 8'h06);
        cyc(3);
        chk("cc on a", 8'h01, {6'h0, gate_cc_en});
        chk("hi gate sink", 8'h02, {6'h0, high_rail_gate_ctrl});
        chk("lo gate src", 8'h01, {6'h0, low_rail_gate_ctrl});
        chk("aux on a", 8'h01, {6'h0, aux_output});
        // a short overload inside the filter time leaves power on
        @(posedge mclk) main_oc_detect <= 2'h1;
        cyc(FLT_SIM - 4);
        @(posedge mclk) main_oc_detect <= 2'h0;
        cyc(4);
        chk("no trip", 8'h01, {6'h0, gate_cc_en});
        // long overload trips main only, irq then cleared by write-one
        trip_a();
        chk("trip main", 8'h00, {6'h0, gate_cc_en});
        chk("aux kept", 8'h01, {6'h0, aux_output});
        chk("irq set", 8'h00, {7'h0, irq_n});
        wr(REG_STAT, 8'h01);
        cyc(2);
        chk("irq clr", 8'h01, {7'h0, irq_n});
        rd_chk("stat after", REG_STAT, 8'h00);
        // masked fault still reports status but no interrupt
        wr(REG_MASK, 8'h01);
        trip_a();
        chk("irq masked", 8'h01, {7'h0, irq_n});
        rd_chk("stat main a", REG_STAT, 8'h01);
        rd_chk("stat read clr", REG_STAT, 8'h00);
        // power bits dropped before the pins take over slot power
        wr(REG_CTRL, 8'h00);
        // pin mode: slot b from pins, power bits in ctrl ignored
        wr(REG_CTRL, 8'h01);
        @(posedge mclk) pin_mode <= 1'b1;
        want_main         <= 2'h2;
        want_aux          <= 2'h2;
        general_input_pin <= 2'h2;
        cyc(PULSE_CYCLES + 8);
        chk("pin cc b", 8'h02, {6'h0, gate_cc_en});
        chk("pin aux b", 8'h02, {6'h0, aux_output});
        wr(REG_CTRL, 8'h1f);
        cyc(3);
        chk("ctrl ignored", 8'h02, {6'h0, gate_cc_en});
        rd_chk("gpi level", REG_PINS, 8'h02);
        // aux overload flags the slot fault pin within a microsecond
        @(posedge mclk) aux_oc_detect <= 2'h2;
        cyc(200);
        chk("fault b", 8'h01, {6'h0, slot_fault_n});
        @(posedge mclk) aux_oc_detect <= 2'h0;
        // standby loss while powered drops everything and requalifies
        @(posedge mclk) standby_supply <= 1'b0;
        pin_mode <= 1'b0;
        cyc(4);
        chk("drop cc", 8'h00, {6'h0, gate_cc_en});
        chk("drop aux", 8'h00, {6'h0, aux_output});
        chk("drop ready", 8'h00, {7'h0, reg_ready});
        @(posedge mclk) standby_supply <= 1'b1;
        cyc(1);
        chk("requal cc", 8'h00, {6'h0, gate_cc_en});
        wait_ready(wait_n);
        chk("requal late", 8'h01, {7'h0, wait_n >= POR_SIM});
        rd_chk("ctrl again", REG_CTRL, 8'h00);
        wrap_up();
    end
endmodule
